// *** rtl/alarm_trim_regs.svh ***
// Purpose: register indices, field positions and reset values
// Assumes: byte address on the bus is four times the index below
// Notes:   definitions only
`ifndef ALARM_TRIM_REGS_SVH
`define ALARM_TRIM_REGS_SVH

// register indices (byte address = index * 4)
`define IDX_AGGREGATE   10'h2c0
`define IDX_FLAGS       10'h2c1
`define IDX_MASK        10'h2c2
`define IDX_LANES       10'h2c4
`define IDX_A_DUAL      10'h310
`define IDX_B_DUAL      10'h313
`define IDX_A_S1        10'h314
`define IDX_B_S1        10'h315
`define IDX_A_S2        10'h31a
`define IDX_CTRL        10'h3f0

// alarm source bit positions, shared by flags and mask
`define BIT_LANE_BUF    5
`define BIT_SYNTH_LOCK  4
`define BIT_SERIAL_LINK 3
`define BIT_REALIGN     2
`define BIT_OSC_PHASE   1
`define BIT_DIV_MISM    0

// control register bit positions
`define CTRL_CAL_SEL    0
`define CTRL_SINGLE     1
`define CTRL_FG_EN      2
`define CTRL_IN2        3

// widths
`define SRC_W           6
`define LANE_W          16
`define TRIM_W          8
`define CTRL_W          4

// reset values
`define RST_MASK        6'h3f
`define RST_FLAGS       6'h3f
`define RST_LANES       16'hffff
`define RST_TRIM        8'h00
`define RST_CTRL        4'h0

`endif

// *** rtl/alarm_trim_pkg.sv ***
// Purpose: shared types for the alarm mask and timing trim bank
// Assumes: constants live in alarm_trim_regs.svh
// Notes:   none
`include "alarm_trim_regs.svh"

package alarm_trim_pkg;

    // the five trim bytes, travelling together
    typedef struct packed {
        logic [7:0] a_dual;
        logic [7:0] b_dual;
        logic [7:0] a_s1;
        logic [7:0] b_s1;
        logic [7:0] a_s2;
    } trim_set_t;

    // operating mode and pin select, mirrors the control register
    typedef struct packed {
        logic in2;
        logic fg_en;
        logic single;
        logic cal_sel;
    } mode_ctrl_t;

    // trim routing, gray coded along dual -> dual fg -> single in1 -> in2
    typedef enum logic [1:0] {
        ROUTE_DUAL       = 2'b00,
        ROUTE_DUAL_FG    = 2'b01,
        ROUTE_SINGLE_IN1 = 2'b11,
        ROUTE_SINGLE_IN2 = 2'b10
    } trim_route_t;

    // word index of an apb byte address
    function automatic logic [9:0] idx_of(input logic [11:0] addr);
        idx_of = addr[11:2];
    endfunction : idx_of

endpackage : alarm_trim_pkg

// *** rtl/sticky_flag_bank.sv ***
// Purpose: bank of sticky flags, hardware set, write-one clear
// Assumes: set and clear are one-cycle qualified vectors
// Notes:   set wins over clear in the same cycle
`timescale 1ns/1ns
`default_nettype none

module sticky_flag_bank #(
    parameter int unsigned     W   = 6,
    parameter logic [W-1:0]    RST = '1
) (
    input  wire logic          sys_clk_i,
    input  wire logic          reset_i,
    input  wire logic [W-1:0]  set_i,
    input  wire logic [W-1:0]  clr_i,
    output logic      [W-1:0]  flags_o
);

    logic [W-1:0] flags_q;

    // clear first, then or in events so a simultaneous event survives
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            flags_q <= RST;
        end else begin
            flags_q <= (flags_q & ~clr_i) | set_i;
        end
    end

    assign flags_o = flags_q;

endmodule : sticky_flag_bank

`default_nettype wire

// *** rtl/trim_select.sv ***
// Purpose: route the stored trim bytes to the two converter cores
// Assumes: mode bits are quasi-static
// Notes:   outputs registered, one cycle after a mode or trim change
`timescale 1ns/1ns
`default_nettype none

module trim_select (
    input  wire logic                     sys_clk_i,
    input  wire logic                     reset_i,
    input  wire alarm_trim_pkg::mode_ctrl_t mode_i,
    input  wire alarm_trim_pkg::trim_set_t  trims_i,
    output logic [7:0]                    core_a_trim_o,
    output logic [7:0]                    core_b_trim_o
);
    import alarm_trim_pkg::*;

    trim_route_t route;
    logic [7:0]  a_d;
    logic [7:0]  b_d;
    logic [7:0]  a_q;
    logic [7:0]  b_q;

    // pick the route from mode bits
    always_comb begin
        if (!mode_i.single) begin
            route = mode_i.fg_en ? ROUTE_DUAL_FG : ROUTE_DUAL;
        end else begin
            route = mode_i.in2 ? ROUTE_SINGLE_IN2 : ROUTE_SINGLE_IN1;
        end
    end

    // per core and mode trim field
    always_comb begin
        case (route)
            ROUTE_DUAL, ROUTE_DUAL_FG: begin
                a_d = trims_i.a_dual;                    // [RULE_09]
                b_d = trims_i.b_dual;                    // [RULE_10]
            end
            ROUTE_SINGLE_IN1: begin
                a_d = trims_i.a_s1;                      // [RULE_11]
                b_d = trims_i.b_s1;                      // [RULE_11]
            end
            ROUTE_SINGLE_IN2: begin
                a_d = trims_i.a_s2;                      // [RULE_11]
                // core b on the second input has no field in this bank
                b_d = trims_i.b_dual;
            end
            default: begin
                a_d = trims_i.a_dual;
                b_d = trims_i.b_dual;
            end
        endcase
    end

    // registered so the analog trim lines never see decode glitches
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            a_q <= `RST_TRIM;
            b_q <= `RST_TRIM;
        end else begin
            a_q <= a_d;                                  // [RULE_07]
            b_q <= b_d;
        end
    end

    assign core_a_trim_o = a_q;
    assign core_b_trim_o = b_q;

endmodule : trim_select

`default_nettype wire

// *** rtl/alarm_trim_bank.sv ***
// Purpose: alarm mask, alarm flags, per-lane buffer flags and core
//          timing trims behind an apb slave
// Assumes: all inputs synchronous to sys_clk_i; one cycle apb answer
// Notes:   unmapped word indices answer pslverr with zero data
//
// What this block does
// RULE_01 - six mask bits; a set bit drops its source from aggregate alarm
// RULE_02 - all six mask bits reset to one
// RULE_03 - sixteen per-lane flags, bit i set on lane i buffer over/underflow
// RULE_04 - writing one to a lane flag clears it; it may set again next cycle
// RULE_05 - writing one to the lane buffer alarm flag clears all lane flags
// RULE_06 - every lane flag reads one after reset until cleared
// RULE_07 - eight-bit trim fields set each core sampling instant per mode
// RULE_08 - trims load factory fuse values, readable and writable by software
// RULE_09 - core a in dual mode uses the first trim field
// RULE_10 - core b in dual mode with foreground calibration uses its field
// RULE_11 - single mode picks trim by core and sampled input; core b on the second input keeps the dual-mode b field
// RULE_12 - aggregate alarm is one when any unmasked flag is set
// RULE_13 - six alarm flags reset to one, each cleared by writing one
// RULE_14 - a select bit routes the aggregate alarm onto the status pin
`timescale 1ns/1ns
`default_nettype none

module alarm_trim_bank (
    input  wire logic                       sys_clk_i,
    input  wire logic                       reset_i,
    // apb slave
    input  wire logic [11:0]                paddr_i,
    input  wire logic                       psel_i,
    input  wire logic                       penable_i,
    input  wire logic                       pwrite_i,
    input  wire logic [31:0]                pwdata_i,
    output logic      [31:0]                prdata_o,
    output logic                            pready_o,
    output logic                            pslverr_o,
    // alarm sources and the calibration status input
    input  wire logic [15:0]                lane_xrun_i,
    input  wire logic [4:0]                 alarm_event_i,
    input  wire logic                       cal_status_i,
    // factory trims
    input  wire alarm_trim_pkg::trim_set_t  fuse_trim_i,
    input  wire logic                       fuse_load_i,
    // outputs
    output logic                            irq_o,
    output logic                            calibration_status_pin_o,
    output logic [7:0]                      core_a_trim_o,
    output logic [7:0]                      core_b_trim_o
);
    import alarm_trim_pkg::*;

    logic [9:0]           idx;
    logic                 setup;
    logic                 wr_fire;
    logic [`SRC_W-1:0]    alarm_source_mask_q;
    logic [`SRC_W-1:0]    alarm_source_flags;
    logic [`SRC_W-1:0]    flag_set;
    logic [`SRC_W-1:0]    flag_clr;
    logic [`LANE_W-1:0]   lane_buffer_fault_flags;
    logic [`LANE_W-1:0]   lane_clr;
    logic                 aggregate;
    trim_set_t            trims_q;
    mode_ctrl_t           mode_q;
    logic                 fuse_pend_q;
    logic                 fuse_take;
    logic [31:0]          rdata_d;
    logic                 hit_d;
    logic [31:0]          prdata_q;
    logic                 pready_q;
    logic                 pslverr_q;
    logic                 irq_q;
    logic                 pin_q;

    // bus phase decode
    assign idx     = idx_of(paddr_i);
    assign setup   = psel_i & ~penable_i;
    assign wr_fire = psel_i & penable_i & pready_q & pwrite_i;

    // apb handshake: ready comes in the first access cycle
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            pready_q <= 1'b0;
        end else begin
            pready_q <= setup;
        end
    end

    // read data and error captured at setup, held through the access
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            prdata_q  <= 32'h0000_0000;
            pslverr_q <= 1'b0;
        end else if (setup) begin
            prdata_q  <= pwrite_i ? 32'h0000_0000 : rdata_d;
            pslverr_q <= ~hit_d;
        end else if (pready_q) begin
            prdata_q  <= 32'h0000_0000;
            pslverr_q <= 1'b0;
        end
    end

    // read mux; narrow registers sit in the low bits, upper bits zero
    always_comb begin
        rdata_d = 32'h0000_0000;
        hit_d   = 1'b1;
        case (idx)
            `IDX_AGGREGATE: rdata_d[0] = aggregate;           // [RULE_12]
            `IDX_FLAGS:     rdata_d[`SRC_W-1:0] = alarm_source_flags;
            `IDX_MASK:      rdata_d[`SRC_W-1:0] = alarm_source_mask_q;
            `IDX_LANES:     rdata_d[`LANE_W-1:0] = lane_buffer_fault_flags;
            `IDX_A_DUAL:    rdata_d[7:0] = trims_q.a_dual;    // [RULE_08]
            `IDX_B_DUAL:    rdata_d[7:0] = trims_q.b_dual;
            `IDX_A_S1:      rdata_d[7:0] = trims_q.a_s1;
            `IDX_B_S1:      rdata_d[7:0] = trims_q.b_s1;
            `IDX_A_S2:      rdata_d[7:0] = trims_q.a_s2;
            `IDX_CTRL:      rdata_d[`CTRL_W-1:0] = mode_q;
            default:        hit_d = 1'b0;
        endcase
    end

    // alarm mask register
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            alarm_source_mask_q <= `RST_MASK;                 // [RULE_02]
        end else if (wr_fire && idx == `IDX_MASK) begin
            alarm_source_mask_q <= pwdata_i[`SRC_W-1:0];      // [RULE_01]
        end
    end

    // control register: pin select and converter mode
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            mode_q <= `RST_CTRL;
        end else if (wr_fire && idx == `IDX_CTRL) begin
            mode_q <= pwdata_i[`CTRL_W-1:0];
        end
    end

    // alarm source flags: lane buffer flag is the or of all lane events
    assign flag_set = {|lane_xrun_i, alarm_event_i};
    assign flag_clr = (wr_fire && idx == `IDX_FLAGS) ?
                      pwdata_i[`SRC_W-1:0] : '0;             // [RULE_13]

    sticky_flag_bank #(
        .W   (`SRC_W),
        .RST (`RST_FLAGS)                                     // [RULE_13]
    ) u_source_flags (
        .sys_clk_i (sys_clk_i),
        .reset_i   (reset_i),
        .set_i     (flag_set),
        .clr_i     (flag_clr),
        .flags_o   (alarm_source_flags)
    );

    // lane flags clear per bit, or all at once from the lane buffer flag
    always_comb begin
        lane_clr = '0;
        if (wr_fire && idx == `IDX_LANES) begin
            lane_clr = pwdata_i[`LANE_W-1:0];                 // [RULE_04]
        end
        if (wr_fire && idx == `IDX_FLAGS && pwdata_i[`BIT_LANE_BUF]) begin
            lane_clr = '1;                                    // [RULE_05]
        end
    end

    // a persisting over/underflow re-sets the bit in the clearing cycle
    sticky_flag_bank #(
        .W   (`LANE_W),
        .RST (`RST_LANES)                                     // [RULE_06]
    ) u_lane_flags (
        .sys_clk_i (sys_clk_i),
        .reset_i   (reset_i),
        .set_i     (lane_xrun_i),                             // [RULE_03]
        .clr_i     (lane_clr),
        .flags_o   (lane_buffer_fault_flags)
    );

    // aggregate alarm: any flag whose mask bit is clear
    assign aggregate = |(alarm_source_flags & ~alarm_source_mask_q); // [RULE_12]

    // interrupt and status pin, registered for clean pads
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            irq_q <= 1'b0;
            pin_q <= 1'b0;
        end else begin
            irq_q <= aggregate;                               // [RULE_01]
            pin_q <= mode_q.cal_sel ? aggregate : cal_status_i; // [RULE_14]
        end
    end

    // fuse copy pending for the first cycle after reset release
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            fuse_pend_q <= 1'b1;
        end else begin
            fuse_pend_q <= 1'b0;
        end
    end

    assign fuse_take = fuse_pend_q | fuse_load_i;

    // trims: fuse defaults, software writes take priority over a reload
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            trims_q <= {5{`RST_TRIM}};
        end else begin
            if (fuse_take) begin
                trims_q <= fuse_trim_i;                       // [RULE_08]
            end
            if (wr_fire) begin
                case (idx)
                    `IDX_A_DUAL: trims_q.a_dual <= pwdata_i[7:0]; // [RULE_08]
                    `IDX_B_DUAL: trims_q.b_dual <= pwdata_i[7:0];
                    `IDX_A_S1:   trims_q.a_s1   <= pwdata_i[7:0];
                    `IDX_B_S1:   trims_q.b_s1   <= pwdata_i[7:0];
                    `IDX_A_S2:   trims_q.a_s2   <= pwdata_i[7:0];
                    default:     ;
                endcase
            end
        end
    end

    // route trims to the two cores by mode
    trim_select u_trim_select (
        .sys_clk_i     (sys_clk_i),
        .reset_i       (reset_i),
        .mode_i        (mode_q),
        .trims_i       (trims_q),
        .core_a_trim_o (core_a_trim_o),                       // [RULE_07]
        .core_b_trim_o (core_b_trim_o)
    );

    assign prdata_o                 = prdata_q;
    assign pready_o                 = pready_q;
    assign pslverr_o                = pslverr_q;
    assign irq_o                    = irq_q;
    assign calibration_status_pin_o = pin_q;

endmodule : alarm_trim_bank

`default_nettype wire

// *** tb/alarm_trim_bank_chk.sv ***
// Purpose: port-level assertions for the alarm mask and trim bank
// Assumes: apb answer one cycle after setup, registered outputs
// Notes:   bound to the bank from the bench top file
`timescale 1ns/1ns
`include "alarm_trim_regs.svh"
`default_nettype none

module alarm_trim_bank_chk (
    input wire logic                      sys_clk_i,
    input wire logic                      reset_i,
    input wire logic [11:0]               paddr_i,
    input wire logic                      psel_i,
    input wire logic                      penable_i,
    input wire logic                      pwrite_i,
    input wire logic [31:0]               pwdata_i,
    input wire logic [31:0]               prdata_o,
    input wire logic                      pready_o,
    input wire logic                      pslverr_o,
    input wire logic                      cal_status_i,
    input wire alarm_trim_pkg::trim_set_t fuse_trim_i,
    input wire logic                      irq_o,
    input wire logic                      calibration_status_pin_o,
    input wire logic [7:0]                core_a_trim_o,
    input wire logic [7:0]                core_b_trim_o
);
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (reset_i);

    // bus phases used by several properties
    sequence s_setup;
        psel_i && !penable_i;
    endsequence
    sequence s_mask_all;
        s_setup ##1 (penable_i && pwrite_i && paddr_i[11:2] == `IDX_MASK
                     && pwdata_i[5:0] == 6'h3f);
    endsequence

    // the answer comes exactly one cycle after setup and stands one cycle
    chk_ready_after_setup: assert property (s_setup |=> pready_o)
        else $error("pready missing after setup");
    chk_ready_one_cycle: assert property (pready_o |=> !pready_o)
        else $error("pready held too long");
    chk_data_idle: assert property (!pready_o |-> prdata_o == 32'h0000_0000)
        else $error("read data outside access cycle");
    // low word indices are unmapped and must be refused with zero data
    chk_unmapped_err: assert property (
        s_setup ##0 (paddr_i[11:2] < `IDX_AGGREGATE)
        |=> pslverr_o && prdata_o == 32'h0000_0000)
        else $error("unmapped access not refused");
    chk_irq_reset_low: assert property (
        $fell(reset_i) |-> !irq_o ##1 !irq_o)
        else $error("interrupt raised right after reset");
    chk_pin_follows_cal: assert property (
        $fell(reset_i) |=> calibration_status_pin_o == $past(cal_status_i))
        else $error("status pin not following input after reset");
    chk_mask_hides_all: assert property (s_mask_all |=> ##1 !irq_o)
        else $error("interrupt high with every source masked");
    // fuse copy after reset reaches the dual-mode core outputs
    chk_fuse_to_cores: assert property (
        $fell(reset_i) |-> ##2 core_a_trim_o == $past(fuse_trim_i.a_dual, 2)
        && core_b_trim_o == $past(fuse_trim_i.b_dual, 2))
        else $error("fuse trims not applied after reset");
endmodule : alarm_trim_bank_chk

`default_nettype wire

// *** tb/alarm_trim_bank_bench.sv ***
// Purpose: self-checking bench for the alarm mask and trim bank
// Assumes: one apb transfer at a time, byte address = 4 * index
// Notes:   latencies after a write follow the registered outputs
`timescale 1ns/1ns
`include "alarm_trim_regs.svh"
`default_nettype none

module alarm_trim_bank_bench;
    import alarm_trim_pkg::*;
    logic        clk   = 1'b0;
    logic        rst   = 1'b1;
    logic [11:0] paddr = 12'h000;
    logic        psel  = 1'b0;
    logic        pen   = 1'b0;
    logic        pwr   = 1'b0;
    logic [31:0] pwd   = 32'h0000_0000;
    logic [31:0] prd;
    logic        prdy;
    logic        perr;
    logic [15:0] xrun  = 16'h0000;
    logic [4:0]  evt   = 5'h00;
    logic        cal   = 1'b0;
    trim_set_t   fuse  = 40'h11_2233_4455;
    logic        fload = 1'b0;
    logic        irq;
    logic        pin;
    logic [7:0]  ta;
    logic [7:0]  trb;
    int          err_count  = 0;
    int          num_checks = 0;
    logic [31:0] rv;
    logic        ev;
    logic [9:0]  tidx [5] = '{`IDX_A_DUAL, `IDX_B_DUAL, `IDX_A_S1,
                              `IDX_B_S1, `IDX_A_S2};
    logic [3:0]  mode [4] = '{4'h0, 4'h4, 4'h6, 4'he};
    logic [15:0] tex  [4] = '{16'ha0a1, 16'ha0a1, 16'ha2a3, 16'ha4a1};

    // 250 MHz clock
    always #2 clk = ~clk;

    alarm_trim_bank u_dut (
        .sys_clk_i(clk), .reset_i(rst), .paddr_i(paddr), .psel_i(psel),
        .penable_i(pen), .pwrite_i(pwr), .pwdata_i(pwd), .prdata_o(prd),
        .pready_o(prdy), .pslverr_o(perr), .lane_xrun_i(xrun),
        .alarm_event_i(evt), .cal_status_i(cal), .fuse_trim_i(fuse),
        .fuse_load_i(fload), .irq_o(irq), .calibration_status_pin_o(pin),
        .core_a_trim_o(ta), .core_b_trim_o(trb));

    task automatic final_report;
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : final_report

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask : cmp

    // one apb transfer; request held until pready seen, bounded wait
    task automatic apb(input logic w, input logic [9:0] idx,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel  <= 1'b1;
        pen   <= 1'b0;
        pwr   <= w;
        paddr <= {idx, 2'b00};
        pwd   <= d;
        @(posedge clk);
        pen <= 1'b1;
        // ready, data and error are taken at the rising edge that ends
        // the access, the same edge at which a write lands
        do begin
            @(posedge clk);
            n++;
        end while (prdy !== 1'b1 && n < 50);
        if (prdy !== 1'b1) begin
            err_count++;
            final_report();
        end
        rv = prd;
        ev = perr;
        psel <= 1'b0;
        pen  <= 1'b0;
    endtask : apb

    task automatic wr(input logic [9:0] idx, input logic [31:0] d);
        apb(1'b1, idx, d);
    endtask : wr

    task automatic rd(input logic [9:0] idx, input logic [31:0] exp);
        apb(1'b0, idx, 32'h0000_0000);
        cmp(rv, exp);
    endtask : rd

    // let k edges land, then look mid-cycle
    task automatic step(input int k);
        repeat (k) @(posedge clk);
        @(negedge clk);
    endtask : step

    // main sequence
    initial begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        rd(`IDX_MASK, 32'h0000_003f);
        rd(`IDX_FLAGS, 32'h0000_003f);
        rd(`IDX_LANES, 32'h0000_ffff);
        rd(`IDX_AGGREGATE, 32'h0000_0000);
        for (int k = 0; k < 5; k++) begin
            rd(tidx[k], {24'h0, fuse[39-8*k -: 8]});
        end
        rd(10'h000, 32'h0000_0000);
        cmp({31'h0, ev}, 32'h0000_0001);
        $display("test reset done");
        // lane flags: partial clear, clear against a live fault, clear all
        wr(`IDX_LANES, 32'h0000_00ff);
        rd(`IDX_LANES, 32'h0000_ff00);
        xrun <= 16'h0100;
        wr(`IDX_LANES, 32'h0000_ffff);
        rd(`IDX_LANES, 32'h0000_0100);
        xrun <= 16'h0000;
        wr(`IDX_FLAGS, 32'h0000_0020);
        rd(`IDX_LANES, 32'h0000_0000);
        xrun <= 16'h8001;
        @(posedge clk);
        xrun <= 16'h0000;
        rd(`IDX_LANES, 32'h0000_8001);
        $display("test lanes done");
        // each source alone unmasked, then masked again
        for (int b = 0; b < 6; b++) begin
            wr(`IDX_FLAGS, 32'h0000_003f);
            wr(`IDX_MASK, 32'h0000_003f ^ (32'h1 << b));
            evt  <= 5'(6'h01 << b);
            xrun <= {15'h0, b == 5};
            @(posedge clk);
            evt  <= 5'h00;
            xrun <= 16'h0000;
            step(2);
            cmp({31'h0, irq}, 32'h0000_0001);
            rd(`IDX_AGGREGATE, 32'h0000_0001);
            rd(`IDX_FLAGS, 32'h1 << b);
            wr(`IDX_MASK, 32'h0000_003f);
            step(1);
            cmp({31'h0, irq}, 32'h0000_0000);
        end
        $display("test alarms done");
        // pin select with the aggregate high and the plain input low
        wr(`IDX_MASK, 32'h0000_0000);
        wr(`IDX_CTRL, 32'h0000_0001);
        step(1);
        cmp({31'h0, pin}, 32'h0000_0001);
        wr(`IDX_CTRL, 32'h0000_0000);
        step(1);
        cmp({31'h0, pin}, 32'h0000_0000);
        $display("test pin done");
        // trims: overwrite, read back, then route through every mode
        for (int k = 0; k < 5; k++) begin
            wr(tidx[k], 32'h0000_00a0 + k);
            rd(tidx[k], 32'h0000_00a0 + k);
        end
        for (int m = 0; m < 4; m++) begin
            wr(`IDX_CTRL, {28'h0, mode[m]});
            step(1);
            cmp({16'h0, ta, trb}, {16'h0, tex[m]});
        end
        fload <= 1'b1;
        @(posedge clk);
        fload <= 1'b0;
        rd(`IDX_A_S2, {24'h0, fuse[7:0]});
        $display("test trims done");
        final_report();
    end
endmodule : alarm_trim_bank_bench

bind alarm_trim_bank alarm_trim_bank_chk u_chk (
    .sys_clk_i, .reset_i, .paddr_i, .psel_i, .penable_i, .pwrite_i,
    .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .cal_status_i,
    .fuse_trim_i, .irq_o, .calibration_status_pin_o, .core_a_trim_o,
    .core_b_trim_o);

`default_nettype wire
